// ===== qrvl_pkg.sv
// Purpose: constants shared by the quasi-resonant flyback valley lockout controller
// Assumes: 50 MHz device clock
// Notes: times are held in their own unit, cycle counts derive from them

package qrvl_pkg;

   // ==========================================================
   // clock
   localparam int CLK_NS = 20;

   // ==========================================================
   // documented times
   localparam int LEB_PWM_NS = 275;
   localparam int LEB_SEVERE_NS = 120;
   localparam int STEADY_TOUT_NS = 6000;
   localparam int SS_TOUT_US = 100;
   localparam int MIN_OSC_FREQ_HZ = 27000;
   localparam int SOFTSTART_MS = 4;
   localparam int OVLD_DURATION_MS = 80;
   localparam int SEVERE_TRIP_LIMIT = 4;

   // ==========================================================
   // derived cycle counts (least times round up, longest round down)
   localparam logic [4:0] LEB_PWM_CYC = 5'((LEB_PWM_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [4:0] LEB_SEVERE_CYC = 5'((LEB_SEVERE_NS + CLK_NS - 1) / CLK_NS);
   localparam int STEADY_TOUT_CYC = STEADY_TOUT_NS / CLK_NS;
   localparam int SS_TOUT_CYC = (SS_TOUT_US * 1000) / CLK_NS;
   localparam int CLAMP_CYC = (1000000000 / MIN_OSC_FREQ_HZ) / CLK_NS;
   localparam int SOFTSTART_CYC = (SOFTSTART_MS * 1000000) / CLK_NS;
   localparam int OVLD_CYC = (OVLD_DURATION_MS * 1000000) / CLK_NS;
   localparam logic [2:0] SEVERE_LIMIT = 3'(SEVERE_TRIP_LIMIT);

   // ==========================================================
   // ramp level 5 - 2*fb, feedback word in 10 mV steps
   localparam logic [9:0] RAMP_FIVE_VOLT = 10'h01F4;

   // ==========================================================
   // synchronised input vector positions
   localparam int IN_W = 13;
   localparam int IX_ZCD = 0;
   localparam int IX_PWM = 1;
   localparam int IX_VCOLIM = 2;
   localparam int IX_MAXPK = 3;
   localparam int IX_SEVERE = 4;
   localparam int IX_OPEN = 5;
   localparam int IX_VALLEY = 6;
   localparam int IX_VCO_IN = 9;
   localparam int IX_VCO_OUT = 10;
   localparam int IX_SKIP = 11;
   localparam int IX_HICDONE = 12;

   // ==========================================================
   // switching states
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_ON = 2'b01,
      ST_HALT = 2'b10
   } qrvl_state_e;

endpackage

// ===== qrvl_ctrl.sv
// Purpose: switching control for a quasi-resonant flyback stage with valley lockout
// Assumes: comparator outputs arrive asynchronously; feedback word is on ref_clk
// Notes: one clock, no registers reached by software
// Notes on behaviour
// - pulse ends at peak, restarts after demag
// - count valleys, target from feedback comparators
// - valley below 55 mV: switch or count
// - valley locked until next threshold crossed
// - new comparator blanks its neighbour by direction
// - oscillator mode entry and exit hysteresis
// - oscillator mode uses 12.5 percent limit
// - 27 kHz clamp in oscillator mode resets ramp
// - skip suppresses pulses at very light load
// - ramp beyond 5 minus 2fb fires pulse
// - 6 us timeout stands in for valley
// - soft-start stretches timeout to 100 us
// - 275 ns blanking before peak compare
// - 0.8 V peak cap flags overload
// - overload timer up/down, 80 ms expiry
// - simultaneous trips: pwm wins, timer falls
// - expiry latches off or requests hiccup
// - 1.2 V fault compare after 120 ns
// - four straight faults force hiccup
// - open sense pin disables controller
// - soft-start about 4 ms, blanks OTP
`timescale 1ns/1ps

module qrvl_ctrl
   import qrvl_pkg::*;
#(
   parameter int unsigned SS_TOUT_CYCLES = SS_TOUT_CYC,
   parameter int unsigned SOFTSTART_CYCLES = SOFTSTART_CYC,
   parameter int unsigned OVLD_CYCLES = OVLD_CYC,
   parameter bit LATCH_OPTION = 1'b1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // comparator outputs
   input wire logic demag_sense_input,
   input wire logic cs_pwm_trip,
   input wire logic cs_osc_limit_trip,
   input wire logic cs_max_peak_trip,
   input wire logic cs_severe_trip,
   input wire logic cs_pin_open,
   input wire logic [2:0] fb_valley_cmp,
   input wire logic fb_below_entry,
   input wire logic fb_above_exit,
   input wire logic fb_below_skip,
   input wire logic hiccup_done,
   // feedback word, 10 mV steps
   input wire logic [7:0] flyback_feedback_level,
   // gate and status
   output logic flyback_gate_drive,
   output logic [1:0] valley_sel,
   output logic osc_mode,
   output logic skip_active,
   output logic softstart_active,
   output logic otp_blank,
   output logic overload_latched,
   output logic hiccup_request
);

   // ==========================================================
   // checks and widths
   localparam int TW = $clog2(SS_TOUT_CYCLES + 1);
   localparam int SW = $clog2(SOFTSTART_CYCLES + 1);
   localparam int OW = $clog2(OVLD_CYCLES + 1);

   generate
      if (SS_TOUT_CYCLES <= STEADY_TOUT_CYC || OVLD_CYCLES < 2 || SOFTSTART_CYCLES < 2) begin : g_bad
         $error("qrvl_ctrl: timing parameters out of range");
      end
   endgenerate

   // ==========================================================
   // reset release
   logic [1:0] rst_pipe_q;
   logic rst_sync_n;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_pipe_q <= 2'b00;
      end else begin
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
      end
   end
   assign rst_sync_n = rst_pipe_q[1];

   // ==========================================================
   // input synchroniser, change taken when stages two and three agree
   logic [IN_W-1:0] raw_in;
   logic [IN_W-1:0] s1_q, s2_q, s3_q, in_q, in_prev_q;

   assign raw_in = {hiccup_done, fb_below_skip, fb_above_exit, fb_below_entry, fb_valley_cmp,
                    cs_pin_open, cs_severe_trip, cs_max_peak_trip, cs_osc_limit_trip,
                    cs_pwm_trip, demag_sense_input};

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         in_q <= '0;
         in_prev_q <= '0;
      end else begin
         s1_q <= raw_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         in_q <= (s3_q & ~(s2_q ^ s3_q)) | (in_q & (s2_q ^ s3_q));
         in_prev_q <= in_q;
      end
   end

   // ==========================================================
   // decoded inputs
   wire valley_ev = in_q[IX_ZCD] & ~in_prev_q[IX_ZCD];
   wire cs_open = in_q[IX_OPEN];
   wire [2:0] vcmp = in_q[IX_VALLEY +: 3];

   // ==========================================================
   // state
   qrvl_state_e state_q, state_d;
   logic [1:0] sel_q, vcnt_q;
   logic dir_fall_q, vco_q, skip_q, drive_q;
   logic [4:0] leb_q;
   logic [TW-1:0] tout_q;
   logic [10:0] ramp_q;
   logic [SW-1:0] ss_q;
   logic ss_q_act;
   logic [OW-1:0] ovld_q;
   logic ovld_present_q, latched_q, hiccup_q, sev_seen_q;
   logic [2:0] sev_cnt_q;

   // ==========================================================
   // valley selection with neighbour blanking
   function automatic logic [1:0] therm_count(input logic [2:0] v);
      therm_count = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
   endfunction

   logic [2:0] vcmp_eff;
   logic [1:0] valley_tgt;
   always_comb begin
      vcmp_eff = vcmp;
      for (int k = 0; k < 3; k++) begin
         if (dir_fall_q && (k < int'(sel_q) - 1)) begin
            vcmp_eff[k] = 1'b1;
         end
         if (!dir_fall_q && (k > int'(sel_q))) begin
            vcmp_eff[k] = 1'b0;
         end
      end
      valley_tgt = therm_count(vcmp_eff);
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sel_q <= 2'b00;
         dir_fall_q <= 1'b1;
      end else if (valley_tgt > sel_q) begin
         sel_q <= sel_q + 2'b01;
         dir_fall_q <= 1'b1;
      end else if (valley_tgt < sel_q) begin
         sel_q <= sel_q - 2'b01;
         dir_fall_q <= 1'b0;
      end
   end

   // ==========================================================
   // oscillator mode, skip and soft-start
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         vco_q <= 1'b0;
         skip_q <= 1'b0;
         ss_q <= '0;
         ss_q_act <= 1'b1;
      end else begin
         if (in_q[IX_VCO_IN]) begin
            vco_q <= 1'b1;
         end else if (in_q[IX_VCO_OUT]) begin
            vco_q <= 1'b0;
         end
         skip_q <= vco_q & in_q[IX_SKIP];
         if (ss_q_act) begin
            ss_q <= ss_q + SW'(1);
            ss_q_act <= (ss_q != SW'(SOFTSTART_CYCLES - 1));
         end
      end
   end

   // ==========================================================
   // timing ramp: level 5 - 2*fb, clamp at minimum frequency
   wire [9:0] fb_x2 = {1'b0, flyback_feedback_level, 1'b0};
   wire [9:0] ramp_level = (fb_x2 >= RAMP_FIVE_VOLT) ? 10'h0000 : RAMP_FIVE_VOLT - fb_x2;
   wire ramp_hit = vco_q && ({1'b0, ramp_level} < ramp_q);
   wire clamp_hit = vco_q && (ramp_q == 11'(CLAMP_CYC - 1));

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ramp_q <= '0;
      end else if (!vco_q || ramp_hit || clamp_hit) begin
         ramp_q <= '0;
      end else begin
         ramp_q <= ramp_q + 11'd1;
      end
   end

   // ==========================================================
   // demag timeout
   wire [TW-1:0] tout_lim = ss_q_act ? TW'(SS_TOUT_CYCLES - 1) : TW'(STEADY_TOUT_CYC - 1);
   wire tout_ev = (state_q == ST_OFF) && (tout_q >= tout_lim);

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tout_q <= '0;
      end else if (state_q != ST_OFF || valley_ev || tout_ev) begin
         tout_q <= '0;
      end else begin
         tout_q <= tout_q + TW'(1);
      end
   end

   // ==========================================================
   // on-time decisions
   wire halt = cs_open | latched_q | hiccup_q;
   wire leb1_done = (leb_q >= LEB_PWM_CYC);
   wire leb2_done = (leb_q >= LEB_SEVERE_CYC);
   wire pwm_lim = vco_q ? in_q[IX_VCOLIM] : in_q[IX_PWM];
   wire pwm_end = leb1_done & pwm_lim;
   wire max_end = leb1_done & in_q[IX_MAXPK];
   wire sev_end = leb2_done & in_q[IX_SEVERE];
   wire pulse_end = (state_q == ST_ON) && (pwm_end || max_end || sev_end);
   wire qr_event = ~vco_q & (valley_ev | tout_ev);
   wire qr_fire = qr_event & (vcnt_q >= sel_q);
   wire osc_fire = (ramp_hit | clamp_hit) & ~skip_q;
   wire turn_on = (state_q == ST_OFF) && (qr_fire || osc_fire);
   wire ovld_exp = ovld_q == OW'(OVLD_CYCLES - 1);
   wire sev_exp = pulse_end && sev_end && (sev_cnt_q == SEVERE_LIMIT - 3'd1);

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_OFF: begin
            if (halt) begin
               state_d = ST_HALT;
            end else if (turn_on) begin
               state_d = ST_ON;
            end
         end
         ST_ON: begin
            if (halt || pulse_end) begin
               state_d = ST_OFF;
            end
         end
         ST_HALT: begin
            if (!halt) begin
               state_d = ST_OFF;
            end
         end
         default: state_d = ST_HALT;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_q <= ST_OFF;
         drive_q <= 1'b0;
         leb_q <= '0;
         vcnt_q <= 2'b00;
      end else begin
         state_q <= state_d;
         drive_q <= (state_d == ST_ON);
         leb_q <= (state_q == ST_ON && leb_q != 5'h1F) ? leb_q + 5'd1 : 5'd0;
         if (turn_on) begin
            vcnt_q <= 2'b00;
         end else if (qr_event && !qr_fire && state_q == ST_OFF) begin
            vcnt_q <= vcnt_q + 2'b01;
         end
      end
   end

   // ==========================================================
   // overload timer and fault counters
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ovld_present_q <= 1'b0;
         ovld_q <= '0;
         latched_q <= 1'b0;
         hiccup_q <= 1'b0;
         sev_cnt_q <= 3'd0;
         sev_seen_q <= 1'b0;
      end else begin
         if (pulse_end) begin
            ovld_present_q <= max_end & ~pwm_end;
         end
         if (ovld_exp) begin
            ovld_q <= '0;
         end else if (ovld_present_q) begin
            ovld_q <= ovld_q + OW'(1);
         end else if (ovld_q != '0) begin
            ovld_q <= ovld_q - OW'(1);
         end
         if (ovld_exp && LATCH_OPTION) begin
            latched_q <= 1'b1;
         end
         if ((ovld_exp && !LATCH_OPTION) || sev_exp) begin
            hiccup_q <= 1'b1;
         end else if (in_q[IX_HICDONE]) begin
            hiccup_q <= 1'b0;
         end
         if (pulse_end) begin
            sev_cnt_q <= sev_end ? (sev_exp ? 3'd0 : sev_cnt_q + 3'd1) : 3'd0;
         end
         sev_seen_q <= sev_exp;
      end
   end

   // ==========================================================
   // outputs
   assign flyback_gate_drive = drive_q;
   assign valley_sel = sel_q;
   assign osc_mode = vco_q;
   assign skip_active = skip_q;
   assign softstart_active = ss_q_act;
   assign otp_blank = ss_q_act;
   assign overload_latched = latched_q;
   assign hiccup_request = hiccup_q;

   // ==========================================================
   // assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_sync_n);

   a_blank_pwm: assert property ((state_q == ST_ON && leb_q < LEB_PWM_CYC
      && !sev_end && !halt) |=> drive_q) else $error("pulse ended inside blanking");
   a_severe_blank: assert property ((state_q == ST_ON && leb_q < LEB_SEVERE_CYC)
      |-> !pulse_end) else $error("fault compare inside short blanking");
   a_gate_off_halt: assert property (cs_open
      |=> !drive_q) else $error("gate drove with open sense pin");
   a_skip_no_pulse: assert property ((state_q == ST_OFF && vco_q && skip_q)
      |=> !drive_q) else $error("pulse during skip");
   a_vco_hold: assert property ((vco_q && !in_q[IX_VCO_OUT] && !in_q[IX_VCO_IN])
      |=> vco_q) else $error("oscillator mode left without exit");
   a_ramp_clamp: assert property (clamp_hit
      |=> ramp_q == 11'd0) else $error("ramp not reset at clamp");
   a_vcnt_clear: assert property ((turn_on && !halt)
      |=> vcnt_q == 2'b00 && drive_q) else $error("valley counter not cleared at pulse");
   a_valley_step: assert property (sel_q != $past(sel_q) |->
      (sel_q - $past(sel_q) == 2'b01) || ($past(sel_q) - sel_q == 2'b01))
      else $error("valley selection jumped");
   a_pwm_wins: assert property ((pulse_end && pwm_end && max_end)
      |=> !ovld_present_q) else $error("overload counted despite pwm trip");
   a_ovld_latch: assert property ((ovld_exp && LATCH_OPTION)
      |=> latched_q ##1 !drive_q) else $error("overload expiry did not latch");
   a_sev_hiccup: assert property (sev_seen_q
      |-> hiccup_q) else $error("fourth fault did not hiccup");
   a_tout_subst: assert property ((state_q == ST_OFF && !ss_q_act && !vco_q
      && tout_q == TW'(STEADY_TOUT_CYC - 1)) |-> qr_event)
      else $error("timeout did not stand in for a valley");

   c_valley_pulse: cover property (qr_fire && valley_ev ##[1:30] pulse_end);
   c_osc_pulse: cover property (osc_fire && turn_on);
   c_overload: cover property (ovld_present_q ##1 ovld_q != '0);
   c_sev_trip: cover property (sev_exp);

endmodule

// ===== qrvl_flyback_model.sv
// Purpose: flyback switch, sense resistor and auxiliary winding seen by the controller
// Assumes: trip_sel 0 pwm, 1 peak cap only, 2 pwm with cap, 3 severe fault
// Notes: valleys ring every 40 cycles after turn-off while ring_en is high
`timescale 1ns/1ps

module qrvl_flyback_model (
   // clock
   input wire logic ref_clk,
   // test controls
   input wire logic ring_en,
   input wire logic [1:0] trip_sel,
   // switch side
   input wire logic flyback_gate_drive,
   output logic demag_sense_input,
   output logic cs_pwm_trip,
   output logic cs_osc_limit_trip,
   output logic cs_max_peak_trip,
   output logic cs_severe_trip,
   output logic [3:0] valley_cnt
);
   int on_cyc = 0;
   int off_cyc = 0;

   // =====
   // current ramp while on, ringing while off
   initial begin
      {demag_sense_input, cs_pwm_trip, cs_osc_limit_trip} = 3'h0;
      {cs_max_peak_trip, cs_severe_trip} = 2'h0;
      valley_cnt = 4'h0;
   end

   always @(posedge ref_clk) begin
      if (flyback_gate_drive) begin
         on_cyc <= on_cyc + 1;
         off_cyc <= 0;
         valley_cnt <= 4'h0;
         demag_sense_input <= 1'b0;
         cs_pwm_trip <= (on_cyc >= 3) && (trip_sel != 2'h1);
         cs_osc_limit_trip <= (on_cyc >= 3);
         cs_max_peak_trip <= (on_cyc >= 3) && (trip_sel != 2'h0);
         cs_severe_trip <= (on_cyc >= 1) && (trip_sel == 2'h3);
      end else begin
         on_cyc <= 0;
         off_cyc <= off_cyc + 1;
         {cs_pwm_trip, cs_osc_limit_trip, cs_max_peak_trip, cs_severe_trip} <= 4'h0;
         demag_sense_input <= ring_en && ((off_cyc % 40) >= 30);
         if (ring_en && (off_cyc % 40) == 30) begin
            valley_cnt <= valley_cnt + 4'h1;
         end
      end
   end
endmodule

// ===== tb_qrvl_ctrl.sv
// Purpose: self-checking bench for the valley lockout controller
// Assumes: shortened soft-start, soft-start timeout and overload counts
// Notes: the flyback model answers the gate with trips and valleys
`timescale 1ns/1ps

module tb_qrvl_ctrl;
   import qrvl_pkg::*;
   localparam int SS_T = 400;
   localparam int SS_LEN = 2000;
   localparam int STEADY = 300;

   // =====
   // signals
   logic ref_clk, rst_n, cs_pin_open, fb_below_entry, fb_above_exit, fb_below_skip;
   logic hiccup_done, ring_en, demag_sense_input, cs_pwm_trip, cs_osc_limit_trip;
   logic cs_max_peak_trip, cs_severe_trip, flyback_gate_drive, osc_mode, skip_active;
   logic softstart_active, otp_blank, overload_latched, hiccup_request;
   logic gate_prev = 1'b0;
   logic [2:0] fb_valley_cmp;
   logic [7:0] flyback_feedback_level;
   logic [1:0] trip_sel, valley_sel;
   logic [3:0] valley_cnt;
   logic [4:0] rows [7] = '{5'h00, 5'h05, 5'h0E, 5'h1F, 5'h0E, 5'h05, 5'h00};
   logic [1:0] sev_kind [8] = '{2'h3, 2'h3, 2'h3, 2'h0, 2'h3, 2'h3, 2'h3, 2'h3};
   int error_cnt = 0, num_checks = 0, cyc = 0, n_rise = 0, n_fall = 0, rel_c = 0;
   int rise_t = 0, fall_t = 0, on_len = 0, off_len = 0, period = 0, seen_v = 0;

   qrvl_ctrl #(.SS_TOUT_CYCLES(SS_T), .SOFTSTART_CYCLES(SS_LEN), .OVLD_CYCLES(50),
      .LATCH_OPTION(1'b1)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .demag_sense_input(demag_sense_input),
      .cs_pwm_trip(cs_pwm_trip), .cs_osc_limit_trip(cs_osc_limit_trip),
      .cs_max_peak_trip(cs_max_peak_trip), .cs_severe_trip(cs_severe_trip),
      .cs_pin_open(cs_pin_open), .fb_valley_cmp(fb_valley_cmp),
      .fb_below_entry(fb_below_entry), .fb_above_exit(fb_above_exit),
      .fb_below_skip(fb_below_skip), .hiccup_done(hiccup_done),
      .flyback_feedback_level(flyback_feedback_level),
      .flyback_gate_drive(flyback_gate_drive), .valley_sel(valley_sel),
      .osc_mode(osc_mode), .skip_active(skip_active), .softstart_active(softstart_active),
      .otp_blank(otp_blank), .overload_latched(overload_latched),
      .hiccup_request(hiccup_request));

   qrvl_flyback_model flyback (
      .ref_clk(ref_clk), .ring_en(ring_en), .trip_sel(trip_sel),
      .flyback_gate_drive(flyback_gate_drive), .demag_sense_input(demag_sense_input),
      .cs_pwm_trip(cs_pwm_trip), .cs_osc_limit_trip(cs_osc_limit_trip),
      .cs_max_peak_trip(cs_max_peak_trip), .cs_severe_trip(cs_severe_trip),
      .valley_cnt(valley_cnt));

   // =====
   // clock, gate edge monitor and run limit
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      gate_prev <= flyback_gate_drive;
      if (flyback_gate_drive === 1'b1 && gate_prev === 1'b0) begin
         n_rise <= n_rise + 1;
         off_len <= cyc - fall_t;
         period <= cyc - rise_t;
         rise_t <= cyc;
         seen_v <= valley_cnt;
      end
      if (flyback_gate_drive === 1'b0 && gate_prev === 1'b1) begin
         n_fall <= n_fall + 1;
         on_len <= cyc - rise_t;
         fall_t <= cyc;
      end
      if (cyc == 40000) begin
         error_cnt++;
         close_out();
      end
   end

   // =====
   // tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic in_range(input string name, input int v, input int lo, input int hi);
      check(name, 32'(v >= lo && v <= hi), 1);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask

   // waits for n gate rises, or n falls when fall is set
   task automatic edges(input bit fall, input int n);
      int t;
      t = (fall ? n_fall : n_rise) + n;
      while ((fall ? n_fall : n_rise) < t) @(posedge ref_clk);
      #2;
   endtask

   task automatic quiet(input string name);
      int r0;
      r0 = n_rise;
      idle(600);
      check(name, n_rise - r0, 0);
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // =====
   // main sequence
   initial begin
      rst_n = 1'b0;
      {cs_pin_open, fb_below_entry, fb_above_exit, fb_below_skip} = 4'h0;
      {hiccup_done, ring_en} = 2'h0;
      trip_sel = 2'h0;
      fb_valley_cmp = 3'h0;
      flyback_feedback_level = 8'h00;
      idle(10);
      check("reset_outs", {flyback_gate_drive, valley_sel, osc_mode, skip_active,
         softstart_active, otp_blank, overload_latched, hiccup_request}, 9'h00C);
      rst_n = 1'b1;
      rel_c = cyc;
      idle(3);
      edges(0, 2);
      in_range("ss_tout", off_len, SS_T - 2, SS_T + 8);
      in_range("leb_on", on_len, 14, 24);
      check("otp_blank", otp_blank, 1);
      while (softstart_active === 1'b1) @(posedge ref_clk);
      in_range("ss_len", cyc - rel_c, SS_LEN, SS_LEN + 6);
      idle(1);
      edges(0, 2);
      in_range("tout", off_len, STEADY - 2, STEADY + 8);
      ring_en = 1'b1;
      foreach (rows[i]) begin
         fb_valley_cmp = rows[i][4:2];
         idle(12);
         check("valley_sel", valley_sel, rows[i][1:0]);
         edges(0, 2);
         check("valley_cnt", seen_v, rows[i][1:0] + 1);
      end
      ring_en = 1'b0;
      fb_valley_cmp = 3'h7;
      edges(0, 2);
      in_range("tout_x4", off_len, 4 * STEADY - 4, 4 * STEADY + 16);
      fb_valley_cmp = 3'h0;
      ring_en = 1'b1;
      trip_sel = 2'h2;
      edges(0, 8);
      check("ovl_prec", overload_latched, 0);
      edges(1, 1);
      foreach (sev_kind[i]) begin
         trip_sel = sev_kind[i];
         edges(1, 1);
         idle(3);
         check("hiccup", hiccup_request, i == 7);
      end
      in_range("sev_on", on_len, 6, 12);
      quiet("hic_hold");
      hiccup_done = 1'b1;
      idle(8);
      check("hic_clr", hiccup_request, 0);
      hiccup_done = 1'b0;
      trip_sel = 2'h0;
      cs_pin_open = 1'b1;
      idle(30);
      quiet("open_pin");
      cs_pin_open = 1'b0;
      fb_below_entry = 1'b1;
      idle(8);
      check("osc_in", osc_mode, 1);
      fb_below_entry = 1'b0;
      idle(8);
      check("osc_hold", osc_mode, 1);
      edges(0, 2);
      in_range("ramp_500", period, 498, 520);
      flyback_feedback_level = 8'hC8;
      edges(0, 2);
      in_range("ramp_100", period, 98, 120);
      fb_below_skip = 1'b1;
      idle(30);
      check("skip", skip_active, 1);
      quiet("skip_quiet");
      fb_below_skip = 1'b0;
      fb_above_exit = 1'b1;
      idle(8);
      check("osc_out", osc_mode, 0);
      fb_above_exit = 1'b0;
      flyback_feedback_level = 8'h00;
      edges(1, 1);
      trip_sel = 2'h1;
      edges(1, 1);
      idle(20);
      check("ovl_early", overload_latched, 0);
      idle(400);
      check("ovl_latch", overload_latched, 1);
      quiet("ovl_off");
      rst_n = 1'b0;
      idle(2);
      check("ovl_rst", overload_latched, 0);
      rst_n = 1'b1;
      idle(4);
      check("ss_restart", softstart_active, 1);
      check("rst_gate", flyback_gate_drive, 0);
      close_out();
   end
endmodule
